/* verilog/fsirq_top.sv */
// framer alarm status latching, masking and interrupt request
`timescale 1ns/1ns
`default_nettype none
`include "fsirq_params.svh"

module fsirq_top
#(
	parameter int ADDR_W = `FSIRQ_ADDR_W,
	parameter int DATA_W = `FSIRQ_DATA_W
)
(
	input  wire logic                  core_clk_in,
	input  wire logic                  srst_in,
	input  wire logic [ADDR_W-1:0]     addr_in,
	input  wire logic [DATA_W-1:0]     wr_data_in,
	input  wire logic                  wr_en_in,
	input  wire logic                  rd_en_in,
	output var  logic [DATA_W-1:0]     rd_data_out,
	input  wire fsirq_pkg::fsirq_alarm_s alarm_in,
	input  wire fsirq_pkg::fsirq_t3_ovh_s t3_ovh_in,
	input  wire logic                  tx_frame_start_in,
	input  wire logic                  rx_frame_start_in,
	output var  logic                  tx_frame_pulse_out,
	output var  logic                  rx_frame_pulse_out,
	output var  logic                  irq_out
);

	localparam int NA = `FSIRQ_NUM_ALARM;
	localparam int NS = `FSIRQ_NUM_STAT;

	logic [NS-1:0]              status_reg;
	logic [NS-1:0]              status_next;
	logic [NS-1:0]              mask_reg;
	logic [1:0]                 ctrl_reg;
	logic                       master_reg;
	logic [NA-1:0]              cond_prev_reg;
	logic [NA-1:0]              chg_reg;
	logic [NA-1:0]              chg_next;
	logic [`FSIRQ_FWIN-1:0]     fhist_reg;
	logic [`FSIRQ_MWIN-1:0]     mhist_reg;
	logic                       t3_flost_reg;
	logic [2:0]                 ralm_cnt_reg;
	fsirq_pkg::fsirq_ralm_e     ralm_state_reg;
	fsirq_pkg::fsirq_ralm_e     ralm_state_next;

	// address decode
	wire sel_status = addr_in == `FSIRQ_ADDR_STATUS;
	wire sel_mask   = addr_in == `FSIRQ_ADDR_MASK;
	wire sel_ctrl   = addr_in == `FSIRQ_ADDR_CTRL;
	wire sel_master = addr_in == `FSIRQ_ADDR_MASTER;
	wire rd_status  = rd_en_in && sel_status;
	wire e3_mode    = ctrl_reg[`FSIRQ_CTRL_E3];

	// t3 frame loss windows; e3 takes the external detector
	wire [`FSIRQ_FWIN-1:0] fhist_next = {fhist_reg[`FSIRQ_FWIN-2:0], t3_ovh_in.f_err};
	wire [`FSIRQ_MWIN-1:0] mhist_next = {mhist_reg[`FSIRQ_MWIN-2:0], t3_ovh_in.m_err};
	wire f_trip = t3_ovh_in.f_valid && ($countones(fhist_next) >= `FSIRQ_FERR_LIM);
	wire m_trip = t3_ovh_in.m_valid && ($countones(mhist_next) >= `FSIRQ_MERR_LIM);

	// remote alarm: both x bits zero for four consecutive multiframes sets it, both one for four clears it
	wire x_zero = t3_ovh_in.x_bits == 2'h0;
	wire x_one  = t3_ovh_in.x_bits == 2'h3;
	wire x_opp  = (ralm_state_reg == fsirq_pkg::FSIRQ_RALM_IDLE) ? x_zero : x_one;
	wire ralm_hit = t3_ovh_in.mframe && x_opp && (ralm_cnt_reg == 3'(`FSIRQ_REM_CNT - 1));
	wire ralm_on  = ralm_state_reg == fsirq_pkg::FSIRQ_RALM_ACTIVE;

	always_comb
	begin
		ralm_state_next = ralm_state_reg;
		case (ralm_state_reg)
			fsirq_pkg::FSIRQ_RALM_IDLE:
				if (ralm_hit)
					ralm_state_next = fsirq_pkg::FSIRQ_RALM_ACTIVE;
			fsirq_pkg::FSIRQ_RALM_ACTIVE:
				if (ralm_hit)
					ralm_state_next = fsirq_pkg::FSIRQ_RALM_IDLE;
			default:
				ralm_state_next = fsirq_pkg::FSIRQ_RALM_IDLE;
		endcase
	end

	// far end alarm codes do not feed this bit, software reads them elsewhere
	wire [NA-1:0] cond = {alarm_in.idle_pattern_seen,
		e3_mode ? alarm_in.remote_alarm : ralm_on,
		alarm_in.alarm_indication,
		e3_mode ? alarm_in.frame_lost : t3_flost_reg,
		alarm_in.signal_lost};

	// set wins over the read clear so no event is lost
	assign status_next[NA-1:0] = cond | (status_reg[NA-1:0] & ~{NA{rd_status}});
	assign status_next[`FSIRQ_BIT_TXSOF] = tx_frame_start_in
		| (status_reg[`FSIRQ_BIT_TXSOF] & ~rd_status);
	assign status_next[`FSIRQ_BIT_RXSOF] = rx_frame_start_in
		| (status_reg[`FSIRQ_BIT_RXSOF] & ~rd_status);
	assign chg_next = (cond ^ cond_prev_reg) | (chg_reg & ~{NA{rd_status}});

	// pending sources: alarm changes plus frame start settings
	wire [NS-1:0] pend = {status_reg[`FSIRQ_BIT_RXSOF], status_reg[`FSIRQ_BIT_TXSOF], chg_reg};
	wire irq_next = master_reg && |(pend & mask_reg);

	// read mux; unused bits read zero
	wire [DATA_W-1:0] rd_mux =
		sel_status ? DATA_W'(status_reg) :
		sel_mask   ? DATA_W'(mask_reg) :
		sel_ctrl   ? DATA_W'(ctrl_reg) :
		sel_master ? DATA_W'(master_reg) : '0;

	always_ff @(posedge core_clk_in)
	begin
		if (srst_in)
		begin
			status_reg    <= '0;
			chg_reg       <= '0;
			cond_prev_reg <= '0;
		end
		else
		begin
			status_reg    <= status_next;
			chg_reg       <= chg_next;
			cond_prev_reg <= cond;
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (srst_in)
		begin
			mask_reg   <= `FSIRQ_MASK_RST;
			ctrl_reg   <= `FSIRQ_CTRL_RST;
			master_reg <= `FSIRQ_MASTER_RST;
		end
		else if (wr_en_in)
		begin
			if (sel_mask)
				mask_reg <= wr_data_in[NS-1:0];
			if (sel_ctrl)
				ctrl_reg <= wr_data_in[1:0];
			if (sel_master)
				master_reg <= wr_data_in[`FSIRQ_MASTER_EN];
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (srst_in)
		begin
			fhist_reg    <= '0;
			mhist_reg    <= '0;
			t3_flost_reg <= 1'b0;
		end
		else
		begin
			if (t3_ovh_in.f_valid)
				fhist_reg <= fhist_next;
			if (t3_ovh_in.m_valid)
				mhist_reg <= mhist_next;
			if (f_trip || m_trip)
				t3_flost_reg <= 1'b1;
			else if (t3_ovh_in.resync)
				t3_flost_reg <= 1'b0;
		end
	end

	// counter restarts whenever the run of matching multiframes breaks
	always_ff @(posedge core_clk_in)
	begin
		if (srst_in)
		begin
			ralm_state_reg <= fsirq_pkg::FSIRQ_RALM_IDLE;
			ralm_cnt_reg   <= '0;
		end
		else
		begin
			ralm_state_reg <= ralm_state_next;
			if (t3_ovh_in.mframe)
				ralm_cnt_reg <= (x_opp && !ralm_hit) ? ralm_cnt_reg + 3'h1 : 3'h0;
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (srst_in)
		begin
			rd_data_out        <= '0;
			irq_out            <= 1'b0;
			tx_frame_pulse_out <= 1'b0;
			rx_frame_pulse_out <= 1'b0;
		end
		else
		begin
			rd_data_out        <= rd_en_in ? rd_mux : '0;
			irq_out            <= irq_next;
			tx_frame_pulse_out <= tx_frame_start_in;
			rx_frame_pulse_out <= rx_frame_start_in;
		end
	end

endmodule // fsirq_top
`default_nettype wire

/* verilog/fsirq_params.svh */
// offsets, field positions, reset values and counts for the framer status block
`ifndef FSIRQ_PARAMS_SVH
`define FSIRQ_PARAMS_SVH

`define FSIRQ_ADDR_W          8
`define FSIRQ_DATA_W          16
// register indices; byte address is four times the index
`define FSIRQ_IDX_STATUS      8'h12
`define FSIRQ_IDX_MASK        8'h14
`define FSIRQ_IDX_CTRL        8'h1a
`define FSIRQ_IDX_MASTER      8'h1c
`define FSIRQ_ADDR_STATUS     8'h48
`define FSIRQ_ADDR_MASK       8'h50
`define FSIRQ_ADDR_CTRL       8'h68
`define FSIRQ_ADDR_MASTER     8'h70
// status and mask field positions
`define FSIRQ_BIT_SIG_LOST    0
`define FSIRQ_BIT_FRM_LOST    1
`define FSIRQ_BIT_ALM_IND     2
`define FSIRQ_BIT_REM_ALM     3
`define FSIRQ_BIT_IDLE        4
`define FSIRQ_BIT_TXSOF       5
`define FSIRQ_BIT_RXSOF       6
`define FSIRQ_NUM_ALARM       5
`define FSIRQ_NUM_STAT        7
// control fields
`define FSIRQ_CTRL_E3         0
`define FSIRQ_CTRL_CBIT       1
`define FSIRQ_MASTER_EN       0
// reset values
`define FSIRQ_MASK_RST        7'h00
`define FSIRQ_CTRL_RST        2'h0
`define FSIRQ_MASTER_RST      1'h0
// framing loss windows and thresholds
`define FSIRQ_FWIN            16
`define FSIRQ_FERR_LIM        3
`define FSIRQ_MWIN            4
`define FSIRQ_MERR_LIM        2
// consecutive multiframes for remote alarm set and clear
`define FSIRQ_REM_CNT         4
`define FSIRQ_REM_SPAN_US     426

`endif

/* verilog/fsirq_pkg.sv */
// types shared by the framer status and interrupt block
package fsirq_pkg;

	typedef struct packed {
		logic idle_pattern_seen;
		logic remote_alarm;
		logic alarm_indication;
		logic frame_lost;
		logic signal_lost;
	} fsirq_alarm_s;

	typedef struct packed {
		logic       f_valid;
		logic       f_err;
		logic       m_valid;
		logic       m_err;
		logic       resync;
		logic       mframe;
		logic [1:0] x_bits;
	} fsirq_t3_ovh_s;

	typedef enum logic {
		FSIRQ_RALM_IDLE,
		FSIRQ_RALM_ACTIVE
	} fsirq_ralm_e;

endpackage

/* dv/fsirq_chk.sv */
// assertions on the framer status block ports
`timescale 1ns/1ns
`default_nettype none
`include "fsirq_params.svh"
module fsirq_chk
#(
	parameter int ADDR_W = 8,
	parameter int DATA_W = 16
)
(
	input wire logic                    core_clk_in,
	input wire logic                    srst_in,
	input wire logic [ADDR_W-1:0]       addr_in,
	input wire logic [DATA_W-1:0]       wr_data_in,
	input wire logic                    wr_en_in,
	input wire logic                    rd_en_in,
	input wire logic [DATA_W-1:0]       rd_data_out,
	input wire fsirq_pkg::fsirq_alarm_s alarm_in,
	input wire fsirq_pkg::fsirq_t3_ovh_s t3_ovh_in,
	input wire logic                    tx_frame_start_in,
	input wire logic                    tx_frame_pulse_out,
	input wire logic                    rx_frame_start_in,
	input wire logic                    rx_frame_pulse_out,
	input wire logic                    irq_out
);
	// masks shadowed from bus writes only, so a faulty read path cannot feed them
	logic [6:0] mask_q;
	logic       on_q;
	wire        st_rd = rd_en_in && addr_in == `FSIRQ_ADDR_STATUS;
	wire        no_sof = !tx_frame_start_in && !rx_frame_start_in;
	// t3 overhead and control writes move the alarm state without touching alarm_in
	wire        calm = no_sof && !wr_en_in && t3_ovh_in == '0;
	always_ff @(posedge core_clk_in)
		if (srst_in)
			mask_q <= 7'h00;
		else if (wr_en_in && addr_in == `FSIRQ_ADDR_MASK)
			mask_q <= wr_data_in[6:0];
	always_ff @(posedge core_clk_in)
		if (srst_in)
			on_q <= 1'b0;
		else if (wr_en_in && addr_in == `FSIRQ_ADDR_MASTER)
			on_q <= wr_data_in[0];
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (srst_in);
	rd_idle_a: assert property (!rd_en_in |=> rd_data_out == '0)
		else $error("read data not zero");
	mask_rd_a: assert property (rd_en_in && addr_in == `FSIRQ_ADDR_MASK |=>
		rd_data_out == {9'h000, mask_q}) else $error("mask read mismatch");
	txp_a: assert property (tx_frame_start_in |=> tx_frame_pulse_out)
		else $error("tx pulse missing");
	rxp_a: assert property (rx_frame_start_in |=> rx_frame_pulse_out)
		else $error("rx pulse missing");
	sof_irq_a: assert property (rx_frame_start_in && mask_q[6] && on_q |-> ##[1:3] irq_out)
		else $error("rx frame irq missing");
	lost_set_a: assert property (alarm_in.signal_lost [*3] ##0 st_rd |=> rd_data_out[0])
		else $error("signal lost bit cleared");
	chg_irq_a: assert property ($changed(alarm_in.signal_lost) && mask_q[0] && on_q
		|-> ##[1:3] irq_out) else $error("alarm change irq missing");
	blocked_a: assert property ((!on_q) [*3] |-> !irq_out)
		else $error("irq with master mask off");
	rd_rel_a: assert property (($stable(alarm_in) && calm) [*3] ##0 st_rd ##1
		($stable(alarm_in) && no_sof) |=> !irq_out) else $error("irq held after read");
endmodule // fsirq_chk
bind fsirq_top fsirq_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (.*);
`default_nettype wire

/* dv/fsirq_top_tb.sv */
// self-checking bench for the framer status and interrupt block
`timescale 1ns/1ns
`default_nettype none
`include "fsirq_params.svh"
module fsirq_top_tb;
	logic        clk, rst, we, re, txs, rxs, txp, rxp, irq;
	logic        rd_d = 1'b0;
	logic [7:0]  addr, ovh;
	logic [15:0] wd, rdat, b;
	logic [4:0]  alm;
	logic [31:0] r;
	logic [15:0] exp_q[$];
	int          num_errors, cmp_count;
	int          bits[7] = '{0, 2, 4, 5, 6, 1, 3};
	fsirq_top dut (.core_clk_in(clk), .srst_in(rst), .addr_in(addr), .wr_data_in(wd),
		.wr_en_in(we), .rd_en_in(re), .rd_data_out(rdat), .alarm_in(alm), .t3_ovh_in(ovh),
		.tx_frame_start_in(txs), .rx_frame_start_in(rxs), .tx_frame_pulse_out(txp),
		.rx_frame_pulse_out(rxp), .irq_out(irq));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		re <= 1'b0;
	endtask
	// overhead strobes are single-cycle, so each one is followed by an idle cycle
	task automatic ov(input logic [7:0] v, input int n);
		repeat (n)
		begin
			@(posedge clk);
			ovh <= v;
			@(posedge clk);
			ovh <= 8'h00;
		end
	endtask
	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// read data stand one cycle after the strobe only, so the check is paced by it
	always @(posedge clk)
	begin
		if (rd_d)
			chk(rdat, exp_q.pop_front());
		rd_d <= re;
	end
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		repeat (5000) @(posedge clk);
		num_errors++;
		report_and_stop();
	end
	initial
	begin
		{rst, we, re, txs, rxs} = 5'h10;
		{addr, ovh, wd, alm} = '0;
		r = $urandom(32'h0a12);
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd(`FSIRQ_ADDR_MASK, 16'h0000);
		wr(`FSIRQ_ADDR_STATUS, 16'hffff);
		rd(`FSIRQ_ADDR_STATUS, 16'h0000);
		rd(8'h04, 16'h0000);
		r = $urandom();
		wr(`FSIRQ_ADDR_MASK, r[15:0]);
		rd(`FSIRQ_ADDR_MASK, {9'h000, r[6:0]});
		$display("register test done");
		ov(8'hc0, 3);
		ov(8'h04, 4);
		rd(`FSIRQ_ADDR_STATUS, 16'h000a);
		chk({15'h0, irq}, 16'h0000);
		ov(8'h08, 1);
		ov(8'h07, 4);
		rd(`FSIRQ_ADDR_STATUS, 16'h000a);
		rd(`FSIRQ_ADDR_STATUS, 16'h0000);
		$display("overhead test done");
		wr(`FSIRQ_ADDR_MASTER, 16'h0001);
		wr(`FSIRQ_ADDR_MASK, 16'h005f);
		txs <= 1'b1;
		@(posedge clk);
		txs <= 1'b0;
		repeat (3) @(posedge clk);
		chk({15'h0, irq}, 16'h0000);
		rd(`FSIRQ_ADDR_STATUS, 16'h0020);
		foreach (bits[k])
		begin
			b = 16'h0001 << bits[k];
			if (k == 5)
			begin
				// e3 from here; frame lost and remote alarm follow alarm_in only in e3, so bits 1 and 3 come last
				wr(`FSIRQ_ADDR_CTRL, 16'hffff);
				rd(`FSIRQ_ADDR_CTRL, 16'h0003);
			end
			wr(`FSIRQ_ADDR_MASK, b);
			alm <= b[4:0];
			txs <= b[5];
			rxs <= b[6];
			@(posedge clk);
			{txs, rxs} <= 2'h0;
			@(posedge clk);
			chk({14'h0, txp, rxp}, {14'h0, b[5], b[6]});
			repeat (2) @(posedge clk);
			chk({15'h0, irq}, 16'h0001);
			rd(`FSIRQ_ADDR_STATUS, b);
			repeat (3) @(posedge clk);
			chk({15'h0, irq}, 16'h0000);
			alm <= 5'h00;
			repeat (4) @(posedge clk);
			chk({15'h0, irq}, {15'h0, b[4:0] != 5'h00});
			rd(`FSIRQ_ADDR_STATUS, b & 16'h001f);
			rd(`FSIRQ_ADDR_STATUS, 16'h0000);
			$display("status bit %0d test done", bits[k]);
		end
		repeat (3) @(posedge clk);
		report_and_stop();
	end
endmodule // fsirq_top_tb
`default_nettype wire
